// File: program_space_address_gen_test.sv
// self-checking bench of the program space address generator
`timescale 1ns/100ps
module program_space_address_gen_test
    import psag_pkg::*;
;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_valid = 1'b0, pc_step = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    psag_req_t req = '0;
    logic pready, pslverr, busy, ptr_wb_en, dmem_en, dmem_we, pmem_rd, pmem_we, pmem_cfg, rd_valid;
    logic [15:0] ea, ptr_wb, operand_value, dmem_addr, dmem_wdata, rd_data, c_daddr, c_wb, c_rd;
    logic [23:0] pmem_rdata, pmem_addr, pmem_wdata, c_paddr, c_pwd;
    logic [2:0] pmem_wmask, c_mask;
    logic [22:0] pc;
    logic [13:0] interrupt_disable_instr_count;
    logic got_d, got_wb, got_p, got_we, got_rd, c_cfg, c_dwe, er;
    int error_cnt = 0, checked = 0, cyc = 0, t_rd = 0, t_tbl = 0;

    always #5 pclk = ~pclk;

    psag_core #(.AW(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .req_valid, .req, .pc_step, .pmem_rdata, .busy, .ea,
        .ptr_wb, .ptr_wb_en, .operand_value, .dmem_en, .dmem_we, .dmem_addr, .dmem_wdata,
        .pmem_rd, .pmem_we, .pmem_cfg, .pmem_addr, .pmem_wdata, .pmem_wmask, .rd_valid,
        .rd_data, .pc, .interrupt_disable_instr_count);
    psag_pmem u_pm (.pmem_rd, .pmem_addr, .pmem_rdata);

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic psag_req_t mk(psag_mode_t m, psag_op_t o, logic bm, logic [15:0] p,
                                     logic [15:0] b, logic [15:0] l, logic [15:0] v);
        return '{mode:m, op:o, byte_mode:bm, share_off:1'b0, ptr:p, base:b, lit:l, modv:v,
                 faddr:l[12:0], wdata:16'hc35a};
    endfunction : mk

    function automatic logic [23:0] pw(input logic [23:0] x);
        return {x[23:16] ^ x[7:0], x[15:0] ^ 16'h3c3c};
    endfunction : pw

    // one request, then six cycles of watching every strobe
    task automatic issue(input psag_req_t r);
        @(posedge pclk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge pclk);
        req_valid <= 1'b0;
        {got_d, got_wb, got_p, got_we, got_rd} = '0;
        for (int i = 1; i < 7; i++) begin
            #1;
            if (dmem_en === 1'b1) {got_d, c_dwe, c_daddr} = {1'b1, dmem_we, dmem_addr};
            if (ptr_wb_en === 1'b1) {got_wb, c_wb} = {1'b1, ptr_wb};
            if (pmem_rd === 1'b1 && !got_p) {got_p, c_cfg, c_paddr} = {1'b1, pmem_cfg, pmem_addr};
            if (pmem_we === 1'b1) {got_we, c_mask, c_pwd} = {1'b1, pmem_wmask, pmem_wdata};
            if (rd_valid === 1'b1) {got_rd, c_rd, t_rd} = {1'b1, rd_data, i};
            @(posedge pclk);
        end
    endtask : issue

    task automatic trd(input logic [7:0] pg, input logic [15:0] a, input psag_op_t o,
                       input logic bm, input logic [15:0] exp, input logic [15:0] m);
        apb(1'b1, OFS_TBL_PAGE, {24'h0, pg});
        issue(mk(M_IND, o, bm, a, 16'h0, 16'h0, 16'h0));
        chk(c_paddr, {pg, a});
        chk(c_cfg, pg[7]);
        chk(c_rd & m, exp);
    endtask : trd

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        apb(1'b0, OFS_TBL_PAGE, 32'h0);
        chk(rv, {24'h0, TBL_PAGE_RST});
        apb(1'b1, OFS_CORE_CTRL, 32'hffffffff);
        apb(1'b0, OFS_CORE_CTRL, 32'h0);
        chk(rv, 32'h4);
        apb(1'b0, 8'h40, 32'h0);
        chk(rv, 32'h0);
        chk(er, 32'h1);
        apb(1'b1, OFS_CORE_CTRL, 32'h0);
    endtask : t_regs

    task automatic t_modes;
        psag_req_t r;
        issue(mk(M_IND, OP_RD, 1'b0, 16'h8ff0, 16'h0, 16'h0, 16'h0));
        chk({got_d, c_daddr}, 32'h18ff0);
        chk(ea, 32'h8ff0);
        issue(mk(M_POST, OP_RD, 1'b0, 16'h8ff0, 16'h0, 16'h0, 16'hfffe));
        chk({c_daddr, c_wb}, 32'h8ff08fee);
        issue(mk(M_PRE, OP_WR, 1'b0, 16'h8ff0, 16'h0, 16'h0, 16'h0002));
        chk(c_dwe, 32'h1);
        chk({c_daddr, c_wb}, 32'h8ff28ff2);
        chk(dmem_wdata, 32'hc35a);
        issue(mk(M_IDX, OP_RD, 1'b0, 16'h8ff0, 16'h0123, 16'h0, 16'h0));
        chk(c_daddr, 32'h9113);
        r = mk(M_IDX, OP_RD, 1'b0, 16'h0010, 16'h0, 16'h0, 16'h0);
        r.share_off = 1'b1;
        issue(r);
        chk(c_daddr, 32'h0133);
        issue(mk(M_LIT, OP_RD, 1'b0, 16'h8ff0, 16'h0, 16'h0010, 16'h0));
        chk(c_daddr, 32'h9000);
        issue(mk(M_FILE, OP_RD, 1'b0, 16'h0, 16'h0, 16'hffff, 16'h0));
        chk(c_daddr, 32'h1fff);
        issue(mk(M_REG, OP_NONE, 1'b0, 16'h5a5a, 16'h0, 16'h0, 16'h0));
        chk(operand_value, 32'h5a5a);
        issue(mk(M_LIT5, OP_NONE, 1'b0, 16'h0, 16'h0, 16'hffff, 16'h0));
        chk(operand_value, 32'h001f);
        issue(mk(M_INTERRUPT_DISABLE_INSTR, OP_NONE, 1'b0, 16'h0, 16'h0, 16'hffff, 16'h0));
        chk(interrupt_disable_instr_count, 32'h3fff);
    endtask : t_modes

    task automatic t_flow;
        chk(pc, 32'h0);
        @(posedge pclk);
        pc_step <= 1'b1;
        @(posedge pclk);
        pc_step <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(pc, 32'h2);
        issue(mk(M_BRA, OP_NONE, 1'b0, 16'h0, 16'h0, 16'h0005, 16'h0));
        chk(pc, 32'he);
        issue(mk(M_BRA, OP_NONE, 1'b0, 16'h0, 16'h0, 16'hfffd, 16'h0));
        chk(pc, 32'ha);
    endtask : t_flow

    task automatic t_table;
        logic [23:0] w, w2, wc, wc2;
        w = pw(24'h124567);
        w2 = pw(24'h124566);
        wc = pw(24'h814567);
        wc2 = pw(24'h814566);
        trd(8'h12, 16'h4567, OP_TRL, 1'b0, w[15:0], 16'hffff);
        t_tbl = t_rd;
        trd(8'h12, 16'h4567, OP_TRL, 1'b1, {8'h0, w[15:8]}, 16'h00ff);
        trd(8'h12, 16'h4566, OP_TRL, 1'b1, {8'h0, w2[7:0]}, 16'h00ff);
        trd(8'h81, 16'h4567, OP_TRH, 1'b0, {8'h0, wc[23:16]}, 16'hffff);
        trd(8'h81, 16'h4567, OP_TRH, 1'b1, 16'h0, 16'h00ff);
        trd(8'h81, 16'h4566, OP_TRH, 1'b1, {8'h0, wc2[23:16]}, 16'h00ff);
        issue(mk(M_IND, OP_TWL, 1'b1, 16'h4567, 16'h0, 16'h0, 16'h0));
        chk({got_d, c_mask, c_pwd[15:8]}, 32'h25a);
        issue(mk(M_IND, OP_TWH, 1'b0, 16'h4566, 16'h0, 16'h0, 16'h0));
        chk({c_mask, c_pwd[23:16]}, 32'h45a);
    endtask : t_table

    task automatic t_window;
        logic [23:0] w;
        w = pw({1'b0, 8'h23, 15'h4321});
        apb(1'b1, OFS_WIN_PAGE, 32'h23);
        apb(1'b1, OFS_CORE_CTRL, 32'h4);
        issue(mk(M_IND, OP_RD, 1'b0, 16'hc321, 16'h0, 16'h0, 16'h0));
        chk(c_paddr, {1'b0, 8'h23, 15'h4321});
        chk({got_d, c_rd}, {1'b0, w[15:0]});
        chk(t_rd - t_tbl, 32'h1);
        issue(mk(M_IND, OP_WR, 1'b0, 16'hc321, 16'h0, 16'h0, 16'h0));
        chk({got_d, got_we}, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rv[ST_DROP_BIT], 32'h1);
        issue(mk(M_IND, OP_RD, 1'b0, 16'h4321, 16'h0, 16'h0, 16'h0));
        chk({got_p, got_d, c_daddr}, 32'h14321);
        apb(1'b1, OFS_CORE_CTRL, 32'h0);
    endtask : t_window

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_flow();
        t_table();
        t_window();
        results();
    end
endmodule : program_space_address_gen_test

// File: psag_core.sv
// address generation for data, table and program space window accesses
// How it works
// - file-register mode takes the 13-bit field as a direct near-data address
// - operand one is register direct; operand two is register, memory or 5-bit literal
// - plain indirect uses the pointer value unchanged as address
// - post-modify uses pointer as address, then adds the constant to it
// - pre-modify adds the signed constant first, then uses the new pointer
// - indexed mode adds pointer and base offset register
// - literal-offset mode adds pointer and instruction literal
// - source and destination share one base offset field
// - branch carries a 16-bit signed literal; interrupt disable a 14-bit count
// - table address is table page above the 16-bit address
// - table page top bit set selects configuration memory
// - window address is zero, window page, low 15 address bits
// - table accesses need no alignment and may read configuration space
// - program counter steps by two per program word
// - table read low word returns program bits 15..0
// - table read low byte picks upper byte when select is one
// - table read high word returns bits 23..16, upper byte zero
// - table read high byte returns zero for the phantom byte
// - only table high operations reach program bits 23..16
// - window accesses are read-only and return only the low word
// - window used only when address top bit and window enable are set
// - a window read takes one extra cycle for two fetches
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
module psag_core
    import psag_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire psag_req_t req,
    input wire logic pc_step,
    input wire logic [PW-1:0] pmem_rdata,
    output logic busy,
    output logic [DW-1:0] ea,
    output logic [DW-1:0] ptr_wb,
    output logic ptr_wb_en,
    output logic [DW-1:0] operand_value,
    output logic dmem_en,
    output logic dmem_we,
    output logic [DW-1:0] dmem_addr,
    output logic [DW-1:0] dmem_wdata,
    output logic pmem_rd,
    output logic pmem_we,
    output logic pmem_cfg,
    output logic [PW-1:0] pmem_addr,
    output logic [PW-1:0] pmem_wdata,
    output logic [2:0] pmem_wmask,
    output logic rd_valid,
    output logic [DW-1:0] rd_data,
    output logic [PCW-1:0] pc,
    output logic [DISIW-1:0] interrupt_disable_instr_count
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [DW-1:0] add16(input logic [DW-1:0] a, input logic [DW-1:0] b);
        add16 = a + b;
    endfunction : add16
    function automatic logic [DW-1:0] fmt(input psag_op_t op, input logic bm,
                                          input logic sel, input logic [PW-1:0] w);
        fmt = w[15:0];
        if (op == OP_TRH) begin
            fmt = (bm && sel) ? 16'h0000 : {8'h00, w[23:16]};
        end else if (bm) begin
            fmt = sel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end
    endfunction : fmt
    // ************************************************************
    // registers and state
    // ************************************************************
    logic [PGW-1:0] tbl_page_r;
    logic [PGW-1:0] win_page_r;
    logic [2:0] core_ctrl_r;
    logic drop_r;
    logic last_win_r;
    logic last_cfg_r;
    logic [DW-1:0] base_hold_r;
    psag_state_t state_r;
    psag_state_t state_nxt;
    psag_op_t op_r;
    logic bm_r;
    logic [DW-1:0] ea_r;
    logic [PW-1:0] pmem_addr_r;
    logic pready_r;
    logic busy_r;
    logic apb_done;
    logic apb_wr;
    logic [DW-1:0] eff;
    logic [DW-1:0] ptr_new;
    logic wb;
    logic [DW-1:0] base_sel;
    logic accept;
    logic is_tbl;
    logic is_tbl_rd;
    logic win_hit;
    logic win_rd;
    logic win_wr;
    logic [PW-1:0] paddr_nxt;

    assign accept = req_valid && (state_r == ST_IDLE);
    assign apb_done = psel && penable && pready_r;
    assign apb_wr = apb_done && pwrite;
    assign busy = busy_r;
    assign ea = ea_r;
    assign pmem_addr = pmem_addr_r;
    assign pready = pready_r;

    // ************************************************************
    // effective address
    // ************************************************************
    always_comb begin
        base_sel = req.share_off ? base_hold_r : req.base;
        eff = 16'h0000;
        ptr_new = req.ptr;
        wb = 1'b0;
        case (req.mode)
            M_FILE: eff = {3'h0, req.faddr};
            M_IND: eff = req.ptr;
            M_POST: begin
                eff = req.ptr;
                ptr_new = add16(req.ptr, req.modv);
                wb = 1'b1;
            end
            M_PRE: begin
                ptr_new = add16(req.ptr, req.modv);
                eff = ptr_new;
                wb = 1'b1;
            end
            M_IDX: eff = add16(req.ptr, base_sel);
            M_LIT: eff = add16(req.ptr, req.lit);
            default: eff = 16'h0000;
        endcase
    end

    always_comb begin
        is_tbl = (req.op == OP_TRL) || (req.op == OP_TRH) ||
                 (req.op == OP_TWL) || (req.op == OP_TWH);
        is_tbl_rd = (req.op == OP_TRL) || (req.op == OP_TRH);
        win_hit = eff[15] && core_ctrl_r[CTRL_WIN_EN_BIT];
        win_rd = (req.op == OP_RD) && win_hit;
        win_wr = (req.op == OP_WR) && win_hit;
        if (is_tbl) begin
            paddr_nxt = {tbl_page_r, eff};
        end else begin
            paddr_nxt = {1'b0, win_page_r, eff[WINW-1:0]};
        end
    end

    // ************************************************************
    // sequencing of program memory reads
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept && win_rd) begin
                    state_nxt = ST_WEXT;
                end else if (accept && is_tbl_rd) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_WEXT: state_nxt = ST_FETCH;
            ST_FETCH: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    // ************************************************************
    // address outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea_r <= 16'h0000;
            ptr_wb <= 16'h0000;
            ptr_wb_en <= 1'b0;
            operand_value <= 16'h0000;
            dmem_en <= 1'b0;
            dmem_we <= 1'b0;
            dmem_addr <= 16'h0000;
            dmem_wdata <= 16'h0000;
            pmem_we <= 1'b0;
            pmem_cfg <= 1'b0;
            pmem_addr_r <= 24'h000000;
            pmem_wdata <= 24'h000000;
            pmem_wmask <= 3'h0;
            op_r <= OP_NONE;
            bm_r <= 1'b0;
            base_hold_r <= 16'h0000;
        end else begin
            ptr_wb_en <= accept && wb;
            dmem_en <= accept && ((req.op == OP_RD) || (req.op == OP_WR)) && !win_hit;
            dmem_we <= accept && (req.op == OP_WR) && !win_hit;
            pmem_we <= accept && ((req.op == OP_TWL) || (req.op == OP_TWH));
            if (accept) begin
                ea_r <= eff;
                ptr_wb <= ptr_new;
                op_r <= win_rd ? OP_RD : req.op;
                bm_r <= req.byte_mode;
                dmem_addr <= eff;
                dmem_wdata <= req.wdata;
                pmem_addr_r <= paddr_nxt;
                pmem_cfg <= is_tbl && tbl_page_r[PAGE_CFG_BIT];
                pmem_wdata <= {req.wdata[7:0], req.wdata};
                pmem_wmask <= 3'h0;
                if (req.op == OP_TWL) begin
                    pmem_wmask <= !req.byte_mode ? 3'h3 : (eff[0] ? 3'h2 : 3'h1);
                    pmem_wdata <= {8'h00, eff[0] && req.byte_mode ? {req.wdata[7:0], 8'h00} :
                                   req.wdata};
                end else if (req.op == OP_TWH) begin
                    // phantom byte write has no lane
                    pmem_wmask <= (req.byte_mode && eff[0]) ? 3'h0 : 3'h4;
                end
                if (req.mode == M_REG) begin
                    operand_value <= req.ptr;
                end else if (req.mode == M_LIT5) begin
                    operand_value <= {11'h000, req.lit[LIT5W-1:0]};
                end
                if (req.mode == M_IDX && !req.share_off) begin
                    base_hold_r <= req.base;
                end
            end
        end
    end

    // ************************************************************
    // program reads and data return
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmem_rd <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            // window read fetches twice, table read once
            pmem_rd <= (accept && (win_rd || is_tbl_rd)) || (state_r == ST_WEXT);
            rd_valid <= (state_r == ST_FETCH);
            if (state_r == ST_FETCH) begin
                rd_data <= fmt(op_r, bm_r, ea_r[0], pmem_rdata);
            end
        end
    end

    // ************************************************************
    // program counter and literal counts
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_RST;
            interrupt_disable_instr_count <= 14'h0000;
        end else begin
            if (accept && req.mode == M_BRA) begin
                pc <= pc + PC_STEP + {{6{req.lit[15]}}, req.lit, 1'b0};
            end else if (pc_step) begin
                pc <= pc + PC_STEP;
            end
            if (accept && req.mode == M_INTERRUPT_DISABLE_INSTR) begin
                interrupt_disable_instr_count <= req.lit[DISIW-1:0];
            end
        end
    end

    // ************************************************************
    // apb register file
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_page_r <= TBL_PAGE_RST;
            win_page_r <= WIN_PAGE_RST;
            core_ctrl_r <= CORE_CTRL_RST;
        end else if (apb_wr) begin
            case (paddr)
                OFS_TBL_PAGE: tbl_page_r <= pwdata[PGW-1:0];
                OFS_WIN_PAGE: win_page_r <= pwdata[PGW-1:0];
                OFS_CORE_CTRL: core_ctrl_r[CTRL_WIN_EN_BIT] <= pwdata[CTRL_WIN_EN_BIT];
                default: core_ctrl_r <= core_ctrl_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_r <= 1'b0;
            last_win_r <= 1'b0;
            last_cfg_r <= 1'b0;
        end else begin
            // a new drop beats a software clear
            if (accept && win_wr) begin
                drop_r <= 1'b1;
            end else if (apb_wr && paddr == OFS_STATUS && pwdata[ST_DROP_BIT]) begin
                drop_r <= 1'b0;
            end
            if (accept) begin
                last_win_r <= win_rd;
                last_cfg_r <= is_tbl && tbl_page_r[PAGE_CFG_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
                case (paddr)
                    OFS_TBL_PAGE: prdata <= {24'h000000, tbl_page_r};
                    OFS_WIN_PAGE: prdata <= {24'h000000, win_page_r};
                    OFS_CORE_CTRL: prdata <= {29'h00000000, core_ctrl_r};
                    OFS_STATUS: prdata <= {28'h0000000, drop_r, last_cfg_r, last_win_r, busy};
                    OFS_LAST_EA: prdata <= {16'h0000, ea_r};
                    OFS_LAST_PADDR: prdata <= {8'h00, pmem_addr_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence seq_win_rd;
        accept && win_rd;
    endsequence
    sequence seq_tbl_rd;
        accept && is_tbl_rd;
    endsequence

    a_file_direct: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept && req.mode == M_FILE |=> ea_r == {3'h0, $past(req.faddr)})
        else $error("file address not direct");
    a_post_modify: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept && req.mode == M_POST |=>
        ea_r == $past(req.ptr) && ptr_wb_en && ptr_wb == $past(req.ptr) + $past(req.modv))
        else $error("post modify wrong");
    a_pre_modify: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept && req.mode == M_PRE |=> ea_r == $past(req.ptr) + $past(req.modv) && ptr_wb_en)
        else $error("pre modify wrong");
    a_table_addr: assert property (
        @(posedge pclk) disable iff (!presetn)
        seq_tbl_rd |=> pmem_addr_r == {$past(tbl_page_r), $past(eff)} && pmem_rd)
        else $error("table address wrong");
    a_cfg_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        seq_tbl_rd |=> pmem_cfg == pmem_addr_r[23])
        else $error("config select wrong");
    a_window_addr: assert property (
        @(posedge pclk) disable iff (!presetn)
        seq_win_rd |=> pmem_addr_r[23] == 1'b0 && pmem_addr_r[15] == $past(win_page_r[0]))
        else $error("window address wrong");
    a_window_extra: assert property (
        @(posedge pclk) disable iff (!presetn)
        seq_win_rd |=> pmem_rd && busy ##1 pmem_rd && busy ##1 rd_valid)
        else $error("window read not one cycle longer");
    a_table_time: assert property (
        @(posedge pclk) disable iff (!presetn)
        seq_tbl_rd |=> !rd_valid ##1 rd_valid)
        else $error("table read timing wrong");
    a_phantom_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_valid && $past(op_r) == OP_TRH |-> rd_data[15:8] == 8'h00)
        else $error("phantom byte not zero");
    a_data_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept && req.op == OP_RD && !win_hit |=> dmem_en && !pmem_rd)
        else $error("data access touched program memory");
    a_pc_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        pc_step && !(accept && req.mode == M_BRA) |=> pc == $past(pc) + PC_STEP)
        else $error("pc step not two");
endmodule : psag_core

// File: psag_pkg.sv
// constants, types and register map of the program space address generator
package psag_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int DW = 16;
    localparam int PW = 24;
    localparam int PCW = 23;
    localparam int FAW = 13;
    localparam int PGW = 8;
    localparam int WINW = 15;
    localparam int DISIW = 14;
    localparam int LIT5W = 5;
    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [7:0] OFS_TBL_PAGE = 8'h00;
    localparam logic [7:0] OFS_WIN_PAGE = 8'h04;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_LAST_EA = 8'h10;
    localparam logic [7:0] OFS_LAST_PADDR = 8'h14;
    localparam int CTRL_WIN_EN_BIT = 2;
    localparam int PAGE_CFG_BIT = 7;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WIN_BIT = 1;
    localparam int ST_CFG_BIT = 2;
    localparam int ST_DROP_BIT = 3;
    localparam logic [7:0] TBL_PAGE_RST = 8'h00;
    localparam logic [7:0] WIN_PAGE_RST = 8'h00;
    localparam logic [2:0] CORE_CTRL_RST = 3'h0;
    localparam logic [22:0] PC_RST = 23'h000000;
    localparam logic [22:0] PC_STEP = 23'h000002;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        M_FILE = 4'h0, M_REG = 4'h1, M_IND = 4'h2, M_POST = 4'h3,
        M_PRE = 4'h4, M_IDX = 4'h5, M_LIT = 4'h6, M_LIT5 = 4'h7,
        M_BRA = 4'h8, M_INTERRUPT_DISABLE_INSTR = 4'h9
    } psag_mode_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_RD = 3'h1, OP_WR = 3'h2, OP_TRL = 3'h3,
        OP_TRH = 3'h4, OP_TWL = 3'h5, OP_TWH = 3'h6
    } psag_op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_WEXT = 2'b01, ST_FETCH = 2'b10
    } psag_state_t;
    typedef struct packed {
        psag_mode_t mode;
        psag_op_t op;
        logic byte_mode;
        logic share_off;
        logic [15:0] ptr;
        logic [15:0] base;
        logic [15:0] lit;
        logic [15:0] modv;
        logic [12:0] faddr;
        logic [15:0] wdata;
    } psag_req_t;
endpackage : psag_pkg

// File: psag_pmem.sv
// program memory model answering the generator's fetches
`timescale 1ns/100ps
module psag_pmem (
    input wire logic pmem_rd,
    input wire logic [23:0] pmem_addr,
    output logic [23:0] pmem_rdata
);
    // ************************************************************
    // fetch answer
    // ************************************************************
    // word stands within the fetch cycle itself; inverted when not fetched
    assign pmem_rdata = pmem_rd ? {pmem_addr[23:16] ^ pmem_addr[7:0], pmem_addr[15:0] ^ 16'h3c3c} :
                        ~{pmem_addr[23:16] ^ pmem_addr[7:0], pmem_addr[15:0] ^ 16'h3c3c};
endmodule : psag_pmem
